/* File: logic/genset_protection.sv */
// Electrical protection and mains/genset transfer logic with an APB register file.
// Assumes measurements synchronous to pclk and an engine block that honours stop/dump.
//
// Summary of operation
// - Current over limit for overcurrent delay raises load dump; zero limit disables.
// - Power over limit for overload timeout raises load dump; zero limit disables.
// - Mains phase voltage outside low/high limits fails mains; auto mode transfers.
// - Mains frequency outside low/high limits fails mains; auto mode transfers.
// - On load, phase under warn limit warns; under shutdown limit stops engine.
// - On load, phase over warn limit warns; over shutdown limit stops engine.
// - Genset voltage shutdowns only after fail delay of continuous excursion; warnings are immediate.
// - Battery low/high warnings, and high-battery shutdown above top limit.
// - Mains back in limits waits mains waiting time before generator contactor opens.
// - To genset: open mains contactor, wait genset contactor time, close generator.
// - To mains: open generator contactor, wait mains contactor time, close mains.
// - Mains order check enabled: wrong sequence warns and opens mains contactor.
// - Negative power beyond limits gives reverse power warning or load dump.
// - Load shed relay on above high limit, off below low, held between.
// - Genset order check enabled: wrong sequence raises load dump.
// - Earth current over limits for earth delay warns or dumps; limits in percent.
// - Currents scaled by CT primary rating against fixed 5 A secondary.
`timescale 1ns/100ps
`include "genset_prot_defines.svh"

module genset_protection
  import genset_prot_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_PERIOD_NS / `PCLK_PERIOD_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire meas_type meas,
  input wire logic gen_ready,
  output relays_type relays,
  output logic irq
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic any_below(input logic [2:0][15:0] v, input logic [15:0] lim);
    any_below = (v[0] < lim) || (v[1] < lim) || (v[2] < lim);
  endfunction

  function automatic logic any_above(input logic [2:0][15:0] v, input logic [15:0] lim);
    any_above = (v[0] > lim) || (v[1] > lim) || (v[2] > lim);
  endfunction

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [31:0] ctrl, oc_lim, pwr_lim, mains_v_lim, mains_f_lim, gen_vlo, gen_vhi;
  logic [31:0] batt_lim, rev_lim, shed_lim, earth_lim, ct_ratio, delays, ctr_time;
  logic [`ST_WIDTH-1:0] status, mask, events;
  logic ack, wr_fire, mapped;
  logic [31:0] live;
  xfer_state_type state;
  logic [15:0] seq_cnt;
  logic [31:0] tick_cnt;
  logic tick;
  logic shed;

  // Second the access phase answers, so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack <= 1'b0;
    end else begin
      ack <= psel && penable && !ack;
    end
  end

  assign pready = psel && penable && ack;
  assign wr_fire = pready && pwrite;

  always_comb begin
    unique case (paddr)
      `OFS_CTRL, `OFS_STATUS, `OFS_MASK, `OFS_LIVE, `OFS_OC_LIM, `OFS_PWR_LIM,
      `OFS_MAINS_V, `OFS_MAINS_F, `OFS_GEN_VLO, `OFS_GEN_VHI, `OFS_BATT,
      `OFS_REV_PWR, `OFS_SHED, `OFS_EARTH, `OFS_CT, `OFS_DELAYS,
      `OFS_CTR_TIME: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Configuration writes land on the pready edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `RST_CTRL;
      mask <= 16'h0000;
      oc_lim <= `RST_OC_LIM;
      pwr_lim <= `RST_PWR_LIM;
      mains_v_lim <= `RST_MAINS_V;
      mains_f_lim <= `RST_MAINS_F;
      gen_vlo <= `RST_GEN_VLO;
      gen_vhi <= `RST_GEN_VHI;
      batt_lim <= `RST_BATT;
      rev_lim <= 32'h0000_0000;
      shed_lim <= 32'h0000_0000;
      earth_lim <= 32'h0000_0000;
      ct_ratio <= `RST_CT;
      delays <= `RST_DELAYS;
      ctr_time <= `RST_CTR_TIME;
    end else if (wr_fire) begin
      case (paddr)
        `OFS_CTRL: ctrl <= {29'h0000_0000, pwdata[2:0]};
        `OFS_MASK: mask <= pwdata[`ST_WIDTH-1:0];
        `OFS_OC_LIM: oc_lim <= {16'h0000, pwdata[15:0]};
        `OFS_PWR_LIM: pwr_lim <= {16'h0000, pwdata[15:0]};
        `OFS_MAINS_V: mains_v_lim <= pwdata;
        `OFS_MAINS_F: mains_f_lim <= pwdata;
        `OFS_GEN_VLO: gen_vlo <= pwdata;
        `OFS_GEN_VHI: gen_vhi <= pwdata;
        `OFS_BATT: batt_lim <= {2'b00, pwdata[29:0]};
        `OFS_REV_PWR: rev_lim <= pwdata;
        `OFS_SHED: shed_lim <= pwdata;
        `OFS_EARTH: earth_lim <= pwdata;
        `OFS_CT: ct_ratio <= pwdata;
        `OFS_DELAYS: delays <= pwdata;
        `OFS_CTR_TIME: ctr_time <= pwdata;
        default: ;
      endcase
    end
  end

  // Read data and error registered in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !ack) begin
      pslverr <= !mapped;
      case (paddr)
        `OFS_CTRL: prdata <= ctrl;
        `OFS_STATUS: prdata <= {16'h0000, status};
        `OFS_MASK: prdata <= {16'h0000, mask};
        `OFS_LIVE: prdata <= live;
        `OFS_OC_LIM: prdata <= oc_lim;
        `OFS_PWR_LIM: prdata <= pwr_lim;
        `OFS_MAINS_V: prdata <= mains_v_lim;
        `OFS_MAINS_F: prdata <= mains_f_lim;
        `OFS_GEN_VLO: prdata <= gen_vlo;
        `OFS_GEN_VHI: prdata <= gen_vhi;
        `OFS_BATT: prdata <= batt_lim;
        `OFS_REV_PWR: prdata <= rev_lim;
        `OFS_SHED: prdata <= shed_lim;
        `OFS_EARTH: prdata <= earth_lim;
        `OFS_CT: prdata <= ct_ratio;
        `OFS_DELAYS: prdata <= delays;
        `OFS_CTR_TIME: prdata <= ctr_time;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // One second timebase
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
    end
  end

  assign tick = (tick_cnt == TICK_CYCLES - 1);

  // ------------------------------------------------------------
  // Comparators
  // ------------------------------------------------------------
  logic mains_bad, on_load, gv_low_warn, gv_high_warn, gv_low_out, gv_high_out;
  logic oc_cond, pwr_cond, earth_w_cond, earth_d_cond, rev_mag_ok;
  logic [15:0] rev_mag;
  logic [47:0] earth_lhs, earth_w_rhs, earth_d_rhs;
  logic [2:0] i_over;

  assign mains_bad = any_below(meas.mains_v, mains_v_lim[15:0])
    || any_above(meas.mains_v, mains_v_lim[31:16])
    || (meas.mains_f < mains_f_lim[15:0])
    || (meas.mains_f > mains_f_lim[31:16]);
  assign on_load = relays.gen_contactor;
  assign gv_low_warn = on_load && any_below(meas.gen_v, gen_vlo[31:16]);
  assign gv_low_out = on_load && any_below(meas.gen_v, gen_vlo[15:0]);
  assign gv_high_warn = on_load && any_above(meas.gen_v, gen_vhi[15:0]);
  assign gv_high_out = on_load && any_above(meas.gen_v, gen_vhi[31:16]);

  // Primary amps compared without a divider: i_sec*ratio > limit*5 A
  generate
    for (genvar p = 0; p < 3; p++) begin : g_phase
      assign i_over[p] = ({16'h0000, meas.gen_i_ma[p]} * {16'h0000, ct_ratio[15:0]})
        > ({16'h0000, oc_lim[15:0]} * 32'(`CT_SECONDARY_MA));
    end
  endgenerate

  assign oc_cond = (oc_lim[15:0] != 16'h0000) && (|i_over);
  assign pwr_cond = (pwr_lim[15:0] != 16'h0000)
    && (meas.gen_kw > $signed({1'b0, pwr_lim[14:0]}));
  assign rev_mag = meas.gen_kw[15] ? 16'(-meas.gen_kw) : 16'h0000;
  assign rev_mag_ok = meas.gen_kw[15];

  // Earth: i_e*ratio_e*100 against pct*ratio*5 A, both sides scaled up to primary terms without a divider
  assign earth_lhs = 48'(meas.earth_ma) * 48'(ct_ratio[31:16]) * 48'(`PCT_FULL);
  assign earth_w_rhs = 48'(earth_lim[15:0]) * 48'(ct_ratio[15:0]) * 48'(`CT_SECONDARY_MA);
  assign earth_d_rhs = 48'(earth_lim[31:16]) * 48'(ct_ratio[15:0]) * 48'(`CT_SECONDARY_MA);
  assign earth_w_cond = earth_lhs > earth_w_rhs;
  assign earth_d_cond = earth_lhs > earth_d_rhs;

  // ------------------------------------------------------------
  // Delayed fault timers, seconds counted on the tick
  // ------------------------------------------------------------
  localparam int NDLY = 6;
  logic [NDLY-1:0] dly_cond, dly_done;
  logic [NDLY-1:0][7:0] dly_set;
  logic [7:0] dly_cnt [NDLY];

  assign dly_cond = {earth_d_cond, earth_w_cond, gv_high_out, gv_low_out, pwr_cond, oc_cond};
  assign dly_set = {delays[15:8], delays[15:8], delays[31:24], delays[31:24],
    delays[7:0], delays[23:16]};

  generate
    for (genvar d = 0; d < NDLY; d++) begin : g_dly
      // Any dropout restarts the count from zero
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dly_cnt[d] <= 8'h00;
        end else if (!dly_cond[d]) begin
          dly_cnt[d] <= 8'h00;
        end else if (tick && dly_cnt[d] != 8'hFF) begin
          dly_cnt[d] <= dly_cnt[d] + 8'h01;
        end
      end
      assign dly_done[d] = dly_cond[d] && (dly_cnt[d] >= dly_set[d]);
    end
  endgenerate

  // ------------------------------------------------------------
  // Events and sticky status, set wins over clear
  // ------------------------------------------------------------
  always_comb begin
    events = '0;
    events[`ST_OC_DUMP] = dly_done[0];
    events[`ST_PWR_DUMP] = dly_done[1];
    events[`ST_MAINS_FAIL] = mains_bad;
    events[`ST_GV_LOW_WARN] = gv_low_warn;
    events[`ST_GV_LOW_SD] = dly_done[2];
    events[`ST_GV_HIGH_WARN] = gv_high_warn;
    events[`ST_GV_HIGH_SD] = dly_done[3];
    events[`ST_BATT_LOW_WARN] = meas.batt_dv < {6'h00, batt_lim[9:0]};
    events[`ST_BATT_HIGH_WARN] = meas.batt_dv > {6'h00, batt_lim[19:10]};
    events[`ST_BATT_HIGH_SD] = meas.batt_dv > {6'h00, batt_lim[29:20]};
    events[`ST_MAINS_ORDER_WARN] = ctrl[`CTRL_MAINS_ORDER] && !meas.mains_order_ok;
    events[`ST_REV_WARN] = rev_mag_ok && rev_mag > rev_lim[15:0];
    events[`ST_REV_DUMP] = rev_mag_ok && rev_mag > rev_lim[31:16];
    events[`ST_GEN_ORDER_DUMP] = ctrl[`CTRL_GEN_ORDER] && !meas.gen_order_ok;
    events[`ST_EARTH_WARN] = dly_done[4];
    events[`ST_EARTH_DUMP] = dly_done[5];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      status <= (status & ~((wr_fire && paddr == `OFS_STATUS) ? pwdata[`ST_WIDTH-1:0] : '0))
        | events;
    end
  end

  assign irq = |(status & mask);

  // ------------------------------------------------------------
  // Load shedding relay with hysteresis
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shed <= 1'b0;
    end else if (meas.gen_kw > $signed({1'b0, shed_lim[30:16]})) begin
      shed <= 1'b1;
    end else if (meas.gen_kw < $signed({1'b0, shed_lim[14:0]})) begin
      shed <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Transfer sequencer; a trip only opens the generator side
  // ------------------------------------------------------------
  logic gen_trip, seq_done;

  assign gen_trip = |(status & (`ST_SHUTDOWN_MASK | `ST_DUMP_MASK));
  assign seq_done = (seq_cnt == 16'h0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ON_MAINS;
      seq_cnt <= 16'h0000;
    end else begin
      if (tick && !seq_done) begin
        seq_cnt <= seq_cnt - 16'h0001;
      end
      unique case (state)
        ON_MAINS: begin
          if (ctrl[`CTRL_AUTO] && mains_bad && gen_ready && !gen_trip) begin
            state <= MAINS_OPENING;
            seq_cnt <= {8'h00, ctr_time[7:0]};
          end
        end
        MAINS_OPENING: begin
          if (seq_done) begin
            state <= ON_GEN;
          end
        end
        ON_GEN: begin
          if (!mains_bad) begin
            state <= RETURN_WAIT;
            seq_cnt <= ctr_time[31:16];
          end
        end
        RETURN_WAIT: begin
          if (mains_bad) begin
            state <= ON_GEN;
          end else if (seq_done) begin
            state <= GEN_OPENING;
            seq_cnt <= {8'h00, ctr_time[15:8]};
          end
        end
        GEN_OPENING: begin
          if (seq_done) begin
            state <= ON_MAINS;
          end
        end
      endcase
    end
  end

  // Relay outputs; contactor overlap is impossible by state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relays <= '0;
    end else begin
      relays.mains_contactor <= (state == ON_MAINS)
        && !(ctrl[`CTRL_MAINS_ORDER] && !meas.mains_order_ok);
      relays.gen_contactor <= (state == ON_GEN || state == RETURN_WAIT) && !gen_trip;
      relays.load_shed <= shed;
      relays.engine_stop <= |(status & `ST_SHUTDOWN_MASK);
      relays.load_dump <= |(status & `ST_DUMP_MASK);
      relays.warning <= |(status & `ST_WARN_MASK);
      relays.mains_failed <= mains_bad;
    end
  end

  assign live = {24'h00_0000, 1'b0, state, relays.load_shed, relays.gen_contactor,
    relays.mains_contactor, mains_bad};

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  oc_disabled_a: assert property (oc_lim[15:0] == 16'h0000 |-> !dly_cond[0])
    else $error("overcurrent check active with zero limit");
  pwr_dump_a: assert property (dly_done[1] |=> status[`ST_PWR_DUMP])
    else $error("excess power dump not latched");
  mains_fail_a: assert property (mains_bad
    |=> status[`ST_MAINS_FAIL] && relays.mains_failed)
    else $error("mains failure not flagged");
  gv_warn_a: assert property (gv_low_warn |=> status[`ST_GV_LOW_WARN] ##1 relays.warning)
    else $error("genset low voltage warning lost");
  gv_delay_a: assert property ($rose(status[`ST_GV_HIGH_SD]) |-> $past(dly_done[3]))
    else $error("high voltage alarm before delay");
  batt_sd_a: assert property (meas.batt_dv > {6'h00, batt_lim[29:20]}
    |=> ##1 relays.engine_stop)
    else $error("battery shutdown did not stop engine");
  gen_close_a: assert property ($rose(relays.gen_contactor)
    |-> !$past(relays.mains_contactor))
    else $error("generator closed while mains contactor held");
  no_overlap_a: assert property (!(relays.gen_contactor && relays.mains_contactor))
    else $error("both contactors closed");
  mains_order_a: assert property (ctrl[`CTRL_MAINS_ORDER] && !meas.mains_order_ok
    |=> !relays.mains_contactor)
    else $error("mains contactor held with bad phase order");
  shed_on_a: assert property (meas.gen_kw > $signed({1'b0, shed_lim[30:16]})
    |=> shed ##1 relays.load_shed)
    else $error("load shed relay not set");
  timer_restart_a: assert property (!dly_cond[5] |=> dly_cnt[5] == 8'h00)
    else $error("earth timer not restarted");
  to_gen_c: cover property (state == MAINS_OPENING ##[1:1000] relays.gen_contactor);
  back_c: cover property (state == GEN_OPENING ##1 state == ON_MAINS);
  oc_trip_c: cover property ($rose(status[`ST_OC_DUMP]));
  clr_c: cover property (wr_fire && paddr == `OFS_STATUS && |status);

endmodule

/* File: logic/genset_prot_defines.svh */
// Offsets, field positions, reset values and timing counts of the protection block.
// Assumes a 100 MHz APB clock; included by bare name after the package.
`ifndef GENSET_PROT_DEFINES_SVH
`define GENSET_PROT_DEFINES_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_MASK 8'h08
`define OFS_LIVE 8'h0C
`define OFS_OC_LIM 8'h10
`define OFS_PWR_LIM 8'h14
`define OFS_MAINS_V 8'h18
`define OFS_MAINS_F 8'h1C
`define OFS_GEN_VLO 8'h20
`define OFS_GEN_VHI 8'h24
`define OFS_BATT 8'h28
`define OFS_REV_PWR 8'h2C
`define OFS_SHED 8'h30
`define OFS_EARTH 8'h34
`define OFS_CT 8'h38
`define OFS_DELAYS 8'h3C
`define OFS_CTR_TIME 8'h40

// ------------------------------------------------------------
// Control bits
// ------------------------------------------------------------
`define CTRL_AUTO 0
`define CTRL_MAINS_ORDER 1
`define CTRL_GEN_ORDER 2

// ------------------------------------------------------------
// Status bits (sticky, write one to clear)
// ------------------------------------------------------------
`define ST_OC_DUMP 0
`define ST_PWR_DUMP 1
`define ST_MAINS_FAIL 2
`define ST_GV_LOW_WARN 3
`define ST_GV_LOW_SD 4
`define ST_GV_HIGH_WARN 5
`define ST_GV_HIGH_SD 6
`define ST_BATT_LOW_WARN 7
`define ST_BATT_HIGH_WARN 8
`define ST_BATT_HIGH_SD 9
`define ST_MAINS_ORDER_WARN 10
`define ST_REV_WARN 11
`define ST_REV_DUMP 12
`define ST_GEN_ORDER_DUMP 13
`define ST_EARTH_WARN 14
`define ST_EARTH_DUMP 15
`define ST_WIDTH 16
`define ST_SHUTDOWN_MASK 16'h0250
`define ST_DUMP_MASK 16'hB003
`define ST_WARN_MASK 16'h4DA8

// ------------------------------------------------------------
// Reset values (units: A, kW, V, 0.1 Hz, 0.1 V, %, s)
// ------------------------------------------------------------
`define RST_CTRL 32'h0000_0001
`define RST_OC_LIM 32'h0000_02BC
`define RST_PWR_LIM 32'h0000_01B8
`define RST_MAINS_V 32'h0104_00B4
`define RST_MAINS_F 32'h0226_01C2
`define RST_GEN_VLO 32'h00C8_00BE
`define RST_GEN_VHI 32'h0104_00FA
`define RST_BATT 32'h12C4_88BE
`define RST_CT 32'h01F4_01F4
`define RST_DELAYS 32'h0505_0505
`define RST_CTR_TIME 32'h001E_0101

// ------------------------------------------------------------
// Timing and scaling
// ------------------------------------------------------------
`define PCLK_PERIOD_NS 10
`define TICK_PERIOD_NS 1_000_000_000
`define CT_SECONDARY_MA 5000
`define PCT_FULL 100

`endif

/* File: logic/genset_prot_pkg.sv */
// Types shared by the protection block and its surroundings.
// Measurements arrive already scaled from front-end logic on pclk.
package genset_prot_pkg;

  // Measurement bundle from the acquisition front end
  typedef struct packed {
    logic [2:0][15:0] mains_v;   // V per phase
    logic [15:0] mains_f;        // 0.1 Hz
    logic [2:0][15:0] gen_v;     // V per phase
    logic [2:0][15:0] gen_i_ma;  // CT secondary, mA
    logic signed [15:0] gen_kw;  // Active power, kW
    logic [15:0] batt_dv;        // 0.1 V
    logic [15:0] earth_ma;       // Earth CT secondary, mA
    logic mains_order_ok;
    logic gen_order_ok;
  } meas_type;

  // Relay and summary outputs
  typedef struct packed {
    logic mains_contactor;
    logic gen_contactor;
    logic load_shed;
    logic engine_stop;
    logic load_dump;
    logic warning;
    logic mains_failed;
  } relays_type;

  typedef enum logic [2:0] {
    ON_MAINS,
    MAINS_OPENING,
    ON_GEN,
    RETURN_WAIT,
    GEN_OPENING
  } xfer_state_type;

endpackage

/* File: dv/genset_far_side.sv */
// Far-side model: mains supply, genset and load, seen as measurement levels.
// Assumes the bench sets levels just after pclk edges; all phases share one value.
`timescale 1ns/100ps
module genset_far_side
  import genset_prot_pkg::*;
(
  input wire logic pclk,
  input wire logic [15:0] mains_volt,
  input wire logic [15:0] mains_freq,
  input wire logic [15:0] gen_volt,
  input wire logic [15:0] gen_amp_ma,
  input wire logic signed [15:0] gen_power,
  input wire logic [15:0] batt_volt,
  input wire logic phase_ok,
  input wire logic run,
  output meas_type meas,
  output logic gen_ready
);
  logic [1:0] start_dly;
  // Phases equal; one flag for both sequences; no earth leakage
  always_comb begin
    meas = '0;
    meas.mains_v = {3{mains_volt}};
    meas.mains_f = mains_freq;
    meas.gen_v = {3{gen_volt}};
    meas.gen_i_ma = {3{gen_amp_ma}};
    meas.gen_kw = gen_power;
    meas.batt_dv = batt_volt;
    meas.mains_order_ok = phase_ok;
    meas.gen_order_ok = phase_ok;
  end
  // Engine reports ready two cycles late, never at once
  always_ff @(posedge pclk) begin
    start_dly <= {start_dly[0], run};
  end
  assign gen_ready = start_dly[1];
endmodule

/* File: dv/genset_protection_tb_top.sv */
// Testbench: APB register checks, alarms, transfer timing and load shedding.
// Assumes a short tick parameter so that seconds last twenty cycles.
`timescale 1ns/100ps
`include "genset_prot_defines.svh"
module genset_protection_tb_top
  import genset_prot_pkg::*;
;
  localparam int TK = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, gen_ready, irq, run, err, ph;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [15:0] mv, mf, gv, gi, bv;
  logic signed [15:0] kw;
  meas_type meas;
  relays_type relays;
  logic [6:0] rv;
  int fails, n_compared, n, i;
  logic [7:0] ofs [0:10] = '{8'h00, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h38,
    8'h3C, 8'h40};
  logic [31:0] rst [0:10] = '{32'h0000_0001, 32'h0000_02BC, 32'h0000_01B8, 32'h0104_00B4,
    32'h0226_01C2, 32'h00C8_00BE, 32'h0104_00FA, 32'h12C4_88BE, 32'h01F4_01F4,
    32'h0505_0505, 32'h001E_0101};
  assign rv = relays;
  always #5 pclk = ~pclk;
  genset_protection #(.TICK_CYCLES(TK)) genset_protection_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas),
    .gen_ready(gen_ready), .relays(relays), .irq(irq));
  genset_far_side genset_far_side_inst (.pclk(pclk), .mains_volt(mv), .mains_freq(mf),
    .gen_volt(gv), .gen_amp_ma(gi), .gen_power(kw), .batt_volt(bv), .phase_ok(ph), .run(run),
    .meas(meas), .gen_ready(gen_ready));
  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic wrap_up();
    if (fails == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      fails++;
      wrap_up();
    end
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic sbit(input int b, input logic v);
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk(d[b], v);
  endtask
  // Bounded wait for one relay bit; n returns the edges waited before the matching one
  task automatic wait_bit(input int idx, input logic v, input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge pclk);
      if (rv[idx] === v) break;
    end
    if (n == lim) begin
      fails++;
      wrap_up();
    end
  endtask
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, run} = 6'b00_0000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    {mv, mf, gv, gi, bv} = {16'h00E6, 16'h01F4, 16'h00E6, 16'h0000, 16'h00F0};
    kw = 16'sh0000;
    ph = 1'b1;
    fails = 0;
    n_compared = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(rv[6], 1'b1);
    for (i = 0; i < 11; i++) begin
      apb(1'b0, ofs[i], 32'h0000_0000);
      chk(d, rst[i]);
    end
    // Unmapped place answers with an error and zero data
    apb(1'b0, 8'h44, 32'h0000_0000);
    chk(err, 1'b1);
    chk(d, 32'h0000_0000);
    apb(1'b1, `OFS_STATUS, 32'h0000_FFFF);
    apb(1'b1, `OFS_MASK, 32'h0000_FFFF);
    bv <= 16'h012D;
    wait_bit(3, 1'b1, 10);
    sbit(9, 1'b1);
    chk(irq, 1'b1);
    bv <= 16'h00F0;
    apb(1'b1, `OFS_STATUS, 32'h0000_0300);
    sbit(9, 1'b0);
    chk(irq, 1'b0);
    // Masked event: status sets but interrupt stays low
    apb(1'b1, `OFS_MASK, 32'h0000_0000);
    bv <= 16'h0123;
    wait_bit(1, 1'b1, 10);
    sbit(8, 1'b1);
    chk(irq, 1'b0);
    bv <= 16'h00F0;
    apb(1'b1, `OFS_STATUS, 32'h0000_FFFF);
    apb(1'b1, `OFS_MASK, 32'h0000_FFFF);
    // Transfer with a two-second mains wait to keep the run short
    apb(1'b1, `OFS_CTR_TIME, 32'h0002_0101);
    run <= 1'b1;
    mv <= 16'h00AA;
    wait_bit(6, 1'b0, 20);
    chk(rv[5], 1'b0);
    sbit(2, 1'b1);
    wait_bit(5, 1'b1, 3 * TK);
    chk(rv[6], 1'b0);
    gv <= 16'h00B4;
    wait_bit(1, 1'b1, 10);
    sbit(3, 1'b1);
    sbit(4, 1'b0);
    gv <= 16'h00E6;
    apb(1'b1, `OFS_STATUS, 32'h0000_FFFF);
    mv <= 16'h00E6;
    wait_bit(5, 1'b0, 4 * TK);
    chk(n >= TK, 1'b1);
    chk(rv[6], 1'b0);
    wait_bit(6, 1'b1, 3 * TK);
    run <= 1'b0;
    repeat (4) @(posedge pclk);
    mf <= 16'h01B8;
    wait_bit(0, 1'b1, 10);
    mf <= 16'h01F4;
    wait_bit(0, 1'b0, 10);
    // Overcurrent interrupted once: the delay must start again
    gi <= 16'h1BBC;
    repeat (3 * TK) @(posedge pclk);
    gi <= 16'h0000;
    repeat (3) @(posedge pclk);
    gi <= 16'h1BBC;
    wait_bit(2, 1'b1, 8 * TK);
    chk(n >= 4 * TK, 1'b1);
    sbit(0, 1'b1);
    gi <= 16'h0000;
    apb(1'b1, `OFS_OC_LIM, 32'h0000_0000);
    apb(1'b1, `OFS_STATUS, 32'h0000_FFFF);
    gi <= 16'h1BBC;
    repeat (7 * TK) @(posedge pclk);
    sbit(0, 1'b0);
    gi <= 16'h0000;
    // Load shedding between 100 and 200 kW holds its state
    apb(1'b1, `OFS_SHED, 32'h00C8_0064);
    kw <= 16'sh00FA;
    wait_bit(4, 1'b1, 10);
    kw <= 16'sh0096;
    repeat (5) @(posedge pclk);
    chk(rv[4], 1'b1);
    kw <= 16'sh0032;
    wait_bit(4, 1'b0, 10);
    // Wrong phase order with both checks on: mains opens, warning and dump latch
    apb(1'b1, `OFS_CTRL, 32'h0000_0007);
    ph <= 1'b0;
    wait_bit(6, 1'b0, 10);
    sbit(10, 1'b1);
    sbit(13, 1'b1);
    ph <= 1'b1;
    apb(1'b1, `OFS_CTRL, 32'h0000_0001);
    apb(1'b1, `OFS_STATUS, 32'h0000_FFFF);
    // Reverse power past the warning limit but short of the dump limit
    apb(1'b1, `OFS_REV_PWR, 32'h0032_000A);
    kw <= 16'shFFEC;
    wait_bit(1, 1'b1, 10);
    sbit(11, 1'b1);
    sbit(12, 1'b0);
    wrap_up();
  end
endmodule
